// [verilog/fcl_regs.svh]
// Offsets, field positions, reset values and sizes of the fuse configuration latch
`ifndef FCL_REGS_SVH
`define FCL_REGS_SVH
// Fuse byte selectors, in the byte-select coding of the programming port
`define FCL_SEL_LOW 2'h0
`define FCL_SEL_LOCK 2'h1
`define FCL_SEL_EXT 2'h2
`define FCL_SEL_HIGH 2'h3
// Signature space offsets
`define FCL_SIG_ZERO 2'h0
`define FCL_SIG_ONE 2'h1
`define FCL_SIG_TWO 2'h2
// Fuse defaults (0 = programmed)
`define FCL_EXT_RESET 8'hFF
`define FCL_HIGH_RESET 8'h99
`define FCL_LOW_RESET 8'h62
`define FCL_LOCK_RESET 8'hFF
// Extended byte: only the low three bits exist
`define FCL_EXT_USED_MASK 8'h07
// High fuse byte fields
`define FCL_HI_DEBUG 7
`define FCL_HI_BOUNDARY 6
`define FCL_HI_SERIAL_DL 5
`define FCL_HI_WDT_FORCE 4
`define FCL_HI_EE_KEEP 3
`define FCL_HI_BOOT_MSB 2
`define FCL_HI_BOOT_LSB 1
`define FCL_HI_RST_VEC 0
// Low fuse byte fields
`define FCL_LO_DIV8 7
`define FCL_LO_CLKOUT 6
`define FCL_LO_SUT_MSB 5
`define FCL_LO_SUT_LSB 4
`define FCL_LO_CKSEL_MSB 3
`define FCL_LO_CKSEL_LSB 0
// Lock byte field
`define FCL_LOCK_FIRST 0
// Page word and byte bits for small and large variants
`define FCL_FLASH_WORD_BITS_SMALL 6
`define FCL_FLASH_WORD_BITS_LARGE 7
`define FCL_EE_BYTE_BITS_SMALL 2
`define FCL_EE_BYTE_BITS_LARGE 3
`endif

// [verilog/fcl_pkg.sv]
// Types shared by the fuse configuration latch
package fcl_pkg;
    // Programming interface operations
    typedef enum logic [2:0] {
        FCL_OP_NONE,
        FCL_OP_WRITE_FUSE,
        FCL_OP_WRITE_LOCK,
        FCL_OP_READ_FUSE,
        FCL_OP_READ_SIG,
        FCL_OP_CHIP_ERASE
    } fcl_op_e;
    // Operating mode of the latch
    typedef enum logic [1:0] {
        FCL_MODE_NORMAL,
        FCL_MODE_SERIAL,
        FCL_MODE_PARALLEL
    } fcl_mode_e;
endpackage : fcl_pkg

// [verilog/fcl_sig_rom.sv]
// Signature and calibration byte store with registered read data
`timescale 1ns/10ps
`include "fcl_regs.svh"
module fcl_sig_rom #(
    parameter logic [7:0] SIG_BYTE0 = 8'hA5, // Arbitrary identity value
    parameter logic [7:0] SIG_BYTE1 = 8'h5A, // Arbitrary identity value
    parameter logic [7:0] SIG_BYTE2 = 8'h3C, // Arbitrary identity value
    parameter logic [7:0] CAL_BYTE = 8'h80   // Arbitrary trim value
) (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic clk_en,
    input wire logic [1:0] addr,
    input wire logic hi_sel,
    output logic [7:0] rdata_q
);
    // Read data come out of a register; unmapped offset reads all ones
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            rdata_q <= 8'h00;
        end else if (clk_en) begin
            if (hi_sel) begin
                // Only offset zero carries a calibration byte
                rdata_q <= (addr == `FCL_SIG_ZERO) ? CAL_BYTE : 8'hFF;
            end else begin
                case (addr)
                    `FCL_SIG_ZERO: rdata_q <= SIG_BYTE0;
                    `FCL_SIG_ONE: rdata_q <= SIG_BYTE1;
                    `FCL_SIG_TWO: rdata_q <= SIG_BYTE2;
                    default: rdata_q <= 8'hFF;
                endcase
            end
        end
    end
endmodule : fcl_sig_rom

// [verilog/fcl_page_split.sv]
// Splits Flash and EEPROM addresses into page number and offset in page
`timescale 1ns/10ps
`include "fcl_regs.svh"
module fcl_page_split (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic clk_en,
    input wire logic large_variant,
    input wire logic [14:0] flash_addr,
    input wire logic [10:0] nv_byte_address,
    output logic [6:0] word_in_page_bits_q,
    output logic [7:0] page_number_bits_q,
    output logic [2:0] ee_byte_in_page_q,
    output logic [7:0] ee_page_q
);
    // Registered split; width of the word field depends on the variant
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            word_in_page_bits_q <= 7'h00;
            page_number_bits_q <= 8'h00;
        end else if (clk_en) begin
            if (large_variant) begin
                word_in_page_bits_q <= flash_addr[`FCL_FLASH_WORD_BITS_LARGE-1:0];
                page_number_bits_q <= flash_addr[14:`FCL_FLASH_WORD_BITS_LARGE];
            end else begin
                word_in_page_bits_q <= {1'b0, flash_addr[`FCL_FLASH_WORD_BITS_SMALL-1:0]};
                page_number_bits_q <= flash_addr[13:`FCL_FLASH_WORD_BITS_SMALL];
            end
        end
    end

    // EEPROM split: 4-byte pages small, 8-byte pages large
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            ee_byte_in_page_q <= 3'h0;
            ee_page_q <= 8'h00;
        end else if (clk_en) begin
            if (large_variant) begin
                ee_byte_in_page_q <= nv_byte_address[`FCL_EE_BYTE_BITS_LARGE-1:0];
                ee_page_q <= nv_byte_address[10:`FCL_EE_BYTE_BITS_LARGE];
            end else begin
                ee_byte_in_page_q <= {1'b0, nv_byte_address[`FCL_EE_BYTE_BITS_SMALL-1:0]};
                ee_page_q <= nv_byte_address[9:`FCL_EE_BYTE_BITS_SMALL];
            end
        end
    end
endmodule : fcl_page_split

// [verilog/fcl_fuse_latch.sv]
// Fuse store, working latches, lock gate, signature reads and trim load
//
// Function
// - Four fuse bytes; programmed bit reads zero
// - Extended byte: bits 7..3 one, threshold defaults
// - High bit7 debug off, bit6 boundary port on
// - Bit5 serial download; untouchable in serial mode
// - Bit4 programmed forces watchdog on
// - Bit3 programmed keeps EEPROM through erase
// - Bits2..1 boot size programmed; bit0 vector
// - Low byte: div8, clkout, startup, clock source
// - Clock output fuse drives clock onto pin
// - Startup field defaults to binary 10
// - Debug fuse keeps clocks running in sleep
// - Chip erase leaves fuses unchanged
// - First lock bit programmed rejects fuse writes
// - Latch on programming entry; changes apply on exit
// - EEPROM keep fuse acts immediately
// - Latch fuses at power-up in normal mode
// - Three signature bytes, readable even locked
// - Calibration byte copied to trim at reset
// - Flash page split, 64 or 128 words
// - EEPROM page split, 4 or 8 bytes
// - Only chip erase clears lock bits
`timescale 1ns/10ps
`include "fcl_regs.svh"
module fcl_fuse_latch (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic clk_en,
    input wire logic prog_mode_pin,
    input wire logic serial_mode_pin,
    input wire logic op_valid,
    input wire fcl_pkg::fcl_op_e op_code,
    input wire logic [1:0] op_sel,
    input wire logic [7:0] op_wdata,
    input wire logic large_variant,
    input wire logic [14:0] flash_addr,
    input wire logic [10:0] nv_byte_address,
    input wire logic sleep_req,
    output logic [7:0] op_rdata_q,
    output logic op_done_q,
    output logic op_reject_q,
    output logic [7:0] rc_trim_register_q,
    output logic [3:0] clock_source_q,
    output logic [1:0] startup_time_q,
    output logic clock_divide_by_eight_q,
    output logic clock_pin_output_q,
    output logic watchdog_force_on_q,
    output logic onchip_debug_enable_q,
    output logic boundary_port_enable_q,
    output logic serial_download_enable_q,
    output logic eeprom_keep_on_erase_q,
    output logic [1:0] boot_size_q,
    output logic reset_vector_select_q,
    output logic [2:0] brownout_threshold_q,
    output logic sleep_clock_keep_q,
    output logic [6:0] word_in_page_bits_q,
    output logic [7:0] page_number_bits_q,
    output logic [2:0] ee_byte_in_page_q,
    output logic [7:0] ee_page_q
);
    // Pin synchronisers: first stage feeds only the second
    logic prog_meta_q, prog_sync_q, ser_meta_q, ser_sync_q;
    // Non-volatile fuse store (written bytes)
    logic [7:0] ext_fuse_q, high_fuse_q, low_fuse_q, lock_byte_q;
    // Working latches that drive configuration
    logic [7:0] ext_work_q, high_work_q, low_work_q;
    // Previous synchronised mode, for entry and exit edges
    logic prog_prev_q;
    // Power-up latch pending, and trim load pending
    logic boot_pend_q, trim_pend_q;
    // Signature store read data
    logic [7:0] sig_rdata;
    logic sig_rd_pend_q;
    fcl_pkg::fcl_mode_e mode_q;

    // Two-flop crossing for the programming mode pins
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            prog_meta_q <= 1'b0;
            prog_sync_q <= 1'b0;
            ser_meta_q <= 1'b0;
            ser_sync_q <= 1'b0;
        end else if (clk_en) begin
            prog_meta_q <= prog_mode_pin;
            prog_sync_q <= prog_meta_q;
            ser_meta_q <= serial_mode_pin;
            ser_sync_q <= ser_meta_q;
        end
    end

    // Mode tracking; serial flag sampled while in programming
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            mode_q <= fcl_pkg::FCL_MODE_NORMAL;
            prog_prev_q <= 1'b0;
        end else if (clk_en) begin
            prog_prev_q <= prog_sync_q;
            if (!prog_sync_q) begin
                mode_q <= fcl_pkg::FCL_MODE_NORMAL;
            end else if (ser_sync_q) begin
                mode_q <= fcl_pkg::FCL_MODE_SERIAL;
            end else begin
                mode_q <= fcl_pkg::FCL_MODE_PARALLEL;
            end
        end
    end

    // Merge a write into a fuse byte; extended spare bits stay one
    function automatic logic [7:0] fcl_merge(input logic [1:0] sel, input logic [7:0] old,
                                             input logic [7:0] wd, input logic serial);
        logic [7:0] res;
        res = wd;
        if (sel == `FCL_SEL_EXT) begin
            res = wd | ~`FCL_EXT_USED_MASK;
        end else if (sel == `FCL_SEL_HIGH && serial) begin
            // Serial download enable cannot be touched from serial mode
            res[`FCL_HI_SERIAL_DL] = old[`FCL_HI_SERIAL_DL];
        end
        return res;
    endfunction : fcl_merge

    // Write strobes; fuse writes gated by the first lock bit
    logic in_prog, is_serial, fuse_wr, fuse_rej, lock_wr, erase_op;
    always_comb begin
        in_prog = (mode_q != fcl_pkg::FCL_MODE_NORMAL);
        is_serial = (mode_q == fcl_pkg::FCL_MODE_SERIAL);
        fuse_wr = op_valid && in_prog && op_code == fcl_pkg::FCL_OP_WRITE_FUSE
                  && op_sel != `FCL_SEL_LOCK && lock_byte_q[`FCL_LOCK_FIRST];
        fuse_rej = op_valid && in_prog && op_code == fcl_pkg::FCL_OP_WRITE_FUSE
                   && (op_sel == `FCL_SEL_LOCK || !lock_byte_q[`FCL_LOCK_FIRST]);
        lock_wr = op_valid && in_prog && op_code == fcl_pkg::FCL_OP_WRITE_LOCK;
        erase_op = op_valid && in_prog && op_code == fcl_pkg::FCL_OP_CHIP_ERASE;
    end

    // Fuse store; chip erase deliberately has no path here
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            // Storage model: defaults stand in for the blank part
            ext_fuse_q <= `FCL_EXT_RESET;
            high_fuse_q <= `FCL_HIGH_RESET;
            low_fuse_q <= `FCL_LOW_RESET;
        end else if (clk_en && fuse_wr) begin
            case (op_sel)
                `FCL_SEL_EXT: ext_fuse_q <= fcl_merge(op_sel, ext_fuse_q, op_wdata, is_serial);
                `FCL_SEL_HIGH: high_fuse_q <= fcl_merge(op_sel, high_fuse_q, op_wdata, is_serial);
                default: low_fuse_q <= fcl_merge(op_sel, low_fuse_q, op_wdata, is_serial);
            endcase
        end
    end

    // Lock bits: writes only program (AND), erase returns them to ones
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            lock_byte_q <= `FCL_LOCK_RESET;
        end else if (clk_en) begin
            if (erase_op) begin
                lock_byte_q <= `FCL_LOCK_RESET;
            end else if (lock_wr) begin
                // AND keeps any write from clearing a programmed bit
                lock_byte_q <= lock_byte_q & op_wdata;
            end
        end
    end

    // Latch events: power-up in normal mode, entry to programming, exit
    logic latch_now;
    always_comb begin
        latch_now = (boot_pend_q && !prog_sync_q)
                    || (prog_sync_q && !prog_prev_q)
                    || (!prog_sync_q && prog_prev_q);
    end

    // Power-up latch pending flag, cleared once taken
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            boot_pend_q <= 1'b1;
        end else if (clk_en && !prog_sync_q) begin
            boot_pend_q <= 1'b0;
        end
    end

    // Working latches hold steady between latch events
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            ext_work_q <= `FCL_EXT_RESET;
            high_work_q <= `FCL_HIGH_RESET;
            low_work_q <= `FCL_LOW_RESET;
        end else if (clk_en && latch_now) begin
            ext_work_q <= ext_fuse_q;
            high_work_q <= high_fuse_q;
            low_work_q <= low_fuse_q;
        end
    end

    // Configuration outputs from the working copy
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            clock_source_q <= 4'h2;
            startup_time_q <= 2'h2;
            clock_divide_by_eight_q <= 1'b1;
            clock_pin_output_q <= 1'b0;
            watchdog_force_on_q <= 1'b0;
            onchip_debug_enable_q <= 1'b0;
            boundary_port_enable_q <= 1'b1;
            serial_download_enable_q <= 1'b1;
            boot_size_q <= 2'h0;
            reset_vector_select_q <= 1'b1;
            brownout_threshold_q <= 3'h7;
        end else if (clk_en) begin
            // Flag outputs are active-high enables of programmed (zero) fuses; the vector bit and the multi-bit fields pass through raw
            clock_source_q <= low_work_q[`FCL_LO_CKSEL_MSB:`FCL_LO_CKSEL_LSB];
            startup_time_q <= low_work_q[`FCL_LO_SUT_MSB:`FCL_LO_SUT_LSB];
            clock_divide_by_eight_q <= ~low_work_q[`FCL_LO_DIV8];
            clock_pin_output_q <= ~low_work_q[`FCL_LO_CLKOUT];
            watchdog_force_on_q <= ~high_work_q[`FCL_HI_WDT_FORCE];
            onchip_debug_enable_q <= ~high_work_q[`FCL_HI_DEBUG];
            boundary_port_enable_q <= ~high_work_q[`FCL_HI_BOUNDARY];
            serial_download_enable_q <= ~high_work_q[`FCL_HI_SERIAL_DL];
            boot_size_q <= high_work_q[`FCL_HI_BOOT_MSB:`FCL_HI_BOOT_LSB];
            reset_vector_select_q <= high_work_q[`FCL_HI_RST_VEC];
            brownout_threshold_q <= ext_work_q[2:0];
        end
    end

    // EEPROM keep reads the store, not the latch, so it acts at once
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            eeprom_keep_on_erase_q <= 1'b0;
        end else if (clk_en) begin
            eeprom_keep_on_erase_q <= ~high_fuse_q[`FCL_HI_EE_KEEP];
        end
    end

    // Sleep clock keep: debug enabled holds clocks in any sleep mode
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            sleep_clock_keep_q <= 1'b0;
        end else if (clk_en) begin
            sleep_clock_keep_q <= sleep_req && ~high_work_q[`FCL_HI_DEBUG];
        end
    end

    // Signature store; trim load reads offset zero high byte
    fcl_sig_rom u_sig_rom (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .clk_en(clk_en),
        .addr(trim_pend_q ? `FCL_SIG_ZERO : op_sel),
        .hi_sel(trim_pend_q || op_wdata[0]),
        .rdata_q(sig_rdata)
    );

    // Trim load after reset: ask ROM, take data one cycle later
    logic trim_take_q;
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            trim_pend_q <= 1'b1;
            trim_take_q <= 1'b0;
            rc_trim_register_q <= 8'h00;
        end else if (clk_en) begin
            trim_pend_q <= 1'b0;
            trim_take_q <= trim_pend_q;
            if (trim_take_q) begin
                rc_trim_register_q <= sig_rdata;
            end
        end
    end

    // Read path and completion; signature reads ignore lock state
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            op_rdata_q <= 8'h00;
            op_done_q <= 1'b0;
            op_reject_q <= 1'b0;
            sig_rd_pend_q <= 1'b0;
        end else if (clk_en) begin
            op_done_q <= 1'b0;
            op_reject_q <= 1'b0;
            sig_rd_pend_q <= op_valid && in_prog && op_code == fcl_pkg::FCL_OP_READ_SIG
                             && !trim_pend_q;
            if (sig_rd_pend_q) begin
                op_rdata_q <= sig_rdata;
                op_done_q <= 1'b1;
            end else if (op_valid && in_prog && op_code == fcl_pkg::FCL_OP_READ_FUSE) begin
                case (op_sel)
                    `FCL_SEL_LOW: op_rdata_q <= low_fuse_q;
                    `FCL_SEL_LOCK: op_rdata_q <= lock_byte_q;
                    `FCL_SEL_EXT: op_rdata_q <= ext_fuse_q;
                    default: op_rdata_q <= high_fuse_q;
                endcase
                op_done_q <= 1'b1;
            end else if (fuse_rej) begin
                op_reject_q <= 1'b1;
            end else if (fuse_wr || lock_wr || erase_op) begin
                op_done_q <= 1'b1;
            end
        end
    end

    // Address split into page and offset
    fcl_page_split u_page_split (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .clk_en(clk_en),
        .large_variant(large_variant),
        .flash_addr(flash_addr),
        .nv_byte_address(nv_byte_address),
        .word_in_page_bits_q(word_in_page_bits_q),
        .page_number_bits_q(page_number_bits_q),
        .ee_byte_in_page_q(ee_byte_in_page_q),
        .ee_page_q(ee_page_q)
    );

    // Fuse writes with first lock bit programmed never change the high or low store byte
    AST_LOCK_BLOCKS: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (clk_en && !lock_byte_q[0]) |=> $stable(high_fuse_q) && $stable(low_fuse_q))
        else $error("fuse store changed while locked");
    // Erase leaves the low fuse byte alone and unlocks
    AST_ERASE_KEEPS: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (clk_en && erase_op) |=> $stable(low_fuse_q) && lock_byte_q == 8'hFF)
        else $error("erase touched fuses or kept locks");
    // Working copy stable without latch event
    AST_WORK_STABLE: assert property (@(posedge clk_sys) disable iff (!arst_n)
        !(clk_en && latch_now) |=> $stable(low_work_q) && $stable(high_work_q))
        else $error("working latch moved without event");
    // Keep fuse follows store one cycle later
    AST_KEEP_NOW: assert property (@(posedge clk_sys) disable iff (!arst_n)
        clk_en ##1 clk_en |-> eeprom_keep_on_erase_q == ~$past(high_fuse_q[3]))
        else $error("eeprom keep lagged");
    // Lock bits never rise without erase
    AST_LOCK_ONEWAY: assert property (@(posedge clk_sys) disable iff (!arst_n)
        !erase_op |=> (lock_byte_q & ~$past(lock_byte_q)) == 8'h00)
        else $error("lock bit cleared without erase");
    // Extended spare bits always one
    AST_EXT_SPARE: assert property (@(posedge clk_sys) disable iff (!arst_n)
        ext_fuse_q[7:3] == 5'h1F)
        else $error("extended spare bit programmed");
    // Serial mode cannot change serial download bit
    AST_SERIAL_DL: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (is_serial && fuse_wr) |=> $stable(high_fuse_q[5]))
        else $error("serial download bit changed in serial mode");
    // Trim register loaded two cycles after reset release
    AST_TRIM_LOAD: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (clk_en && trim_take_q) |=> rc_trim_register_q == u_sig_rom.CAL_BYTE)
        else $error("trim not loaded from calibration byte");
    COV_LOCK_REJECT: cover property (@(posedge clk_sys) disable iff (!arst_n) op_reject_q);
    COV_PROG_EXIT: cover property (@(posedge clk_sys) disable iff (!arst_n)
        prog_prev_q && !prog_sync_q);
    COV_SIG_READ: cover property (@(posedge clk_sys) disable iff (!arst_n) sig_rd_pend_q);
endmodule : fcl_fuse_latch

// [test/fcl_prog_model.sv]
// Programmer model issuing one-cycle requests on the fuse programming port
`timescale 1ns/10ps
module fcl_prog_model (
    input wire logic clk_sys,
    input wire logic op_done_q,
    input wire logic op_reject_q,
    output logic op_valid,
    output fcl_pkg::fcl_op_e op_code,
    output logic [1:0] op_sel,
    output logic [7:0] op_wdata
);
    logic timed_out; // No answer came inside the bound
    // Idle port at time zero
    initial begin
        op_valid = 1'b0;
        op_code = fcl_pkg::FCL_OP_NONE;
        op_sel = 2'h0;
        op_wdata = 8'h00;
        timed_out = 1'b0;
    end
    // Pulse one request, then a bounded wait for done or reject
    task automatic run_op(input fcl_pkg::fcl_op_e op, input logic [1:0] sel,
                          input logic [7:0] wd, output logic rej);
        @(negedge clk_sys);
        op_valid = 1'b1;
        op_code = op;
        op_sel = sel;
        op_wdata = wd;
        @(negedge clk_sys);
        op_valid = 1'b0;
        // Released lines carry the inverse, so a stale value never passes
        op_sel = ~sel;
        op_wdata = ~wd;
        timed_out = 1'b1;
        for (int n = 0; n < 4 && timed_out; n++) begin
            if (op_done_q === 1'b1 || op_reject_q === 1'b1) timed_out = 1'b0;
            else @(negedge clk_sys);
        end
        rej = op_reject_q;
    endtask : run_op
endmodule : fcl_prog_model

// [test/fcl_fuse_latch_tb.sv]
// Self-checking bench for the fuse configuration latch
`timescale 1ns/10ps
module fcl_fuse_latch_tb;
    // One request and the answer it should give
    typedef struct {
        fcl_pkg::fcl_op_e op;
        logic [1:0] sel;
        logic [7:0] wd;
        logic [7:0] rd;
        logic rej;
    } fcl_row_s;
    localparam fcl_pkg::fcl_op_e op_rf = fcl_pkg::FCL_OP_READ_FUSE;
    localparam fcl_pkg::fcl_op_e op_rs = fcl_pkg::FCL_OP_READ_SIG;
    localparam fcl_pkg::fcl_op_e op_wf = fcl_pkg::FCL_OP_WRITE_FUSE;
    localparam fcl_pkg::fcl_op_e op_wl = fcl_pkg::FCL_OP_WRITE_LOCK;
    localparam fcl_pkg::fcl_op_e op_ce = fcl_pkg::FCL_OP_CHIP_ERASE;
    logic clk_sys = 1'b0;
    logic arst_n = 1'b0;
    logic clk_en = 1'b1; // Never gated: freeze path left to design assertions
    logic prog_mode_pin = 1'b0;
    logic serial_mode_pin = 1'b0;
    logic large_variant = 1'b0;
    logic sleep_req = 1'b0;
    logic [14:0] flash_addr = 15'h1234;
    logic [10:0] nv_byte_address = 11'h5AB;
    logic op_valid, op_done_q, op_reject_q, clock_divide_by_eight_q, clock_pin_output_q, rej;
    logic watchdog_force_on_q, onchip_debug_enable_q, boundary_port_enable_q, sleep_clock_keep_q;
    logic serial_download_enable_q, eeprom_keep_on_erase_q, reset_vector_select_q;
    fcl_pkg::fcl_op_e op_code;
    logic [1:0] op_sel, startup_time_q, boot_size_q;
    logic [2:0] brownout_threshold_q, ee_byte_in_page_q;
    logic [3:0] clock_source_q;
    logic [6:0] word_in_page_bits_q;
    logic [7:0] op_wdata, op_rdata_q, rc_trim_register_q, page_number_bits_q, ee_page_q;
    int error_cnt = 0;
    int num_checks = 0;
    // Flag outputs and raw fields gathered into bytes for compact compares
    wire logic [7:0] flags = {clock_divide_by_eight_q, clock_pin_output_q, watchdog_force_on_q,
        onchip_debug_enable_q, boundary_port_enable_q, serial_download_enable_q,
        eeprom_keep_on_erase_q, reset_vector_select_q};
    wire logic [7:0] raw = {clock_source_q, startup_time_q, boot_size_q};
    // Ordinary reads and one refusal in programming mode
    fcl_row_s rows [10] = '{'{op_rf, 2'h0, 8'h00, 8'h62, 1'b0}, '{op_rf, 2'h2, 8'h00, 8'hFF, 1'b0},
        '{op_rf, 2'h3, 8'h00, 8'h99, 1'b0}, '{op_rf, 2'h1, 8'h00, 8'hFF, 1'b0},
        '{op_rs, 2'h0, 8'h00, 8'hA5, 1'b0}, '{op_rs, 2'h1, 8'h00, 8'h5A, 1'b0},
        '{op_rs, 2'h2, 8'h00, 8'h3C, 1'b0}, '{op_rs, 2'h0, 8'h01, 8'h80, 1'b0},
        '{op_rs, 2'h3, 8'h00, 8'hFF, 1'b0}, '{op_wf, 2'h1, 8'h00, 8'h00, 1'b1}};
    fcl_fuse_latch dut (.clk_sys(clk_sys), .arst_n(arst_n), .clk_en(clk_en),
        .prog_mode_pin(prog_mode_pin), .serial_mode_pin(serial_mode_pin), .op_valid(op_valid),
        .op_code(op_code), .op_sel(op_sel), .op_wdata(op_wdata), .large_variant(large_variant),
        .flash_addr(flash_addr), .nv_byte_address(nv_byte_address), .sleep_req(sleep_req),
        .op_rdata_q(op_rdata_q), .op_done_q(op_done_q), .op_reject_q(op_reject_q),
        .rc_trim_register_q(rc_trim_register_q), .clock_source_q(clock_source_q),
        .startup_time_q(startup_time_q), .clock_divide_by_eight_q(clock_divide_by_eight_q),
        .clock_pin_output_q(clock_pin_output_q), .watchdog_force_on_q(watchdog_force_on_q),
        .onchip_debug_enable_q(onchip_debug_enable_q), .boot_size_q(boot_size_q),
        .boundary_port_enable_q(boundary_port_enable_q),
        .serial_download_enable_q(serial_download_enable_q),
        .eeprom_keep_on_erase_q(eeprom_keep_on_erase_q), .sleep_clock_keep_q(sleep_clock_keep_q),
        .reset_vector_select_q(reset_vector_select_q), .brownout_threshold_q(brownout_threshold_q),
        .word_in_page_bits_q(word_in_page_bits_q), .page_number_bits_q(page_number_bits_q),
        .ee_byte_in_page_q(ee_byte_in_page_q), .ee_page_q(ee_page_q));
    fcl_prog_model pm (.clk_sys(clk_sys), .op_done_q(op_done_q), .op_reject_q(op_reject_q),
        .op_valid(op_valid), .op_code(op_code), .op_sel(op_sel), .op_wdata(op_wdata));
    always #2.5 clk_sys = ~clk_sys;
    // Verdict, then end of run
    task automatic report_and_stop();
        if (error_cnt == 0 && num_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : report_and_stop
    // Compare one byte-wide result
    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    // One request through the programmer; a missing answer ends the run
    task automatic op_chk(input fcl_row_s r);
        pm.run_op(r.op, r.sel, r.wd, rej);
        if (pm.timed_out) begin
            chk("answer", 8'h01, 8'h00);
            report_and_stop();
        end
        chk("reject", {7'h00, r.rej}, {7'h00, rej});
        if (r.op == op_rf || r.op == op_rs) chk("rdata", r.rd, op_rdata_q);
    endtask : op_chk
    // Main sequence
    initial begin
        repeat (10) @(negedge clk_sys);
        arst_n = 1'b1;
        repeat (5) @(negedge clk_sys);
        chk("flags", 8'h8D, flags);
        chk("raw", 8'h28, raw);
        chk("brownout", 8'h07, {5'h00, brownout_threshold_q});
        chk("trim", 8'h80, rc_trim_register_q);
        sleep_req = 1'b1;
        repeat (2) @(negedge clk_sys);
        chk("sleep", 8'h00, {7'h00, sleep_clock_keep_q});
        // Page split, small then large variant
        for (int v = 0; v < 2; v++) begin
            large_variant = v[0];
            repeat (2) @(negedge clk_sys);
            chk("word", v ? {1'b0, flash_addr[6:0]} : {2'h0, flash_addr[5:0]},
                {1'b0, word_in_page_bits_q});
            chk("page", v ? flash_addr[14:7] : flash_addr[13:6], page_number_bits_q);
            chk("eebyte", v ? {5'h00, nv_byte_address[2:0]} : {6'h00, nv_byte_address[1:0]},
                {5'h00, ee_byte_in_page_q});
            chk("eepage", v ? nv_byte_address[10:3] : nv_byte_address[9:2], ee_page_q);
        end
        prog_mode_pin = 1'b1;
        repeat (6) @(negedge clk_sys);
        foreach (rows[i]) op_chk(rows[i]);
        // Fuses first, lock later; changes wait for exit except the keep fuse
        op_chk('{op_wf, 2'h0, 8'hB2, 8'h00, 1'b0});
        op_chk('{op_wf, 2'h3, 8'h11, 8'h00, 1'b0});
        @(negedge clk_sys);
        chk("flags", 8'h8F, flags);
        prog_mode_pin = 1'b0;
        repeat (6) @(negedge clk_sys);
        chk("flags", 8'h5F, flags);
        chk("sleep", 8'h01, {7'h00, sleep_clock_keep_q});
        chk("raw", 8'h2C, raw);
        prog_mode_pin = 1'b1;
        repeat (6) @(negedge clk_sys);
        // Locked: fuse writes refused until erase, signature still readable
        op_chk('{op_wl, 2'h1, 8'hFE, 8'h00, 1'b0});
        op_chk('{op_wf, 2'h0, 8'hFF, 8'h00, 1'b1});
        op_chk('{op_wl, 2'h1, 8'hFF, 8'h00, 1'b0});
        op_chk('{op_wf, 2'h0, 8'hFF, 8'h00, 1'b1});
        op_chk('{op_rs, 2'h1, 8'h00, 8'h5A, 1'b0});
        op_chk('{op_ce, 2'h0, 8'h00, 8'h00, 1'b0});
        op_chk('{op_rf, 2'h1, 8'h00, 8'hFF, 1'b0});
        op_chk('{op_rf, 2'h0, 8'h00, 8'hB2, 1'b0});
        // Serial mode keeps the download-enable bit programmed
        serial_mode_pin = 1'b1;
        repeat (6) @(negedge clk_sys);
        op_chk('{op_wf, 2'h3, 8'hFF, 8'h00, 1'b0});
        op_chk('{op_rf, 2'h3, 8'h00, 8'hDF, 1'b0});
        report_and_stop();
    end
endmodule : fcl_fuse_latch_tb
